/* File: hw/pit_defines.svh */
`ifndef PIT_DEFINES_SVH
`define PIT_DEFINES_SVH

// ===========================================================================
// instruction parcel layout (16-bit parcel, fields g h i j k)
// ===========================================================================
`define PIT_PARCEL_W      16
`define PIT_F_GH_HI       15
`define PIT_F_GH_LO       9
`define PIT_F_I_HI        8
`define PIT_F_I_LO        6
`define PIT_F_J_HI        5
`define PIT_F_J_LO        3
`define PIT_F_K_HI        2
`define PIT_F_K_LO        0

// ===========================================================================
// opcode values of the four timer instructions
// ===========================================================================
`define PIT_OP_GH         7'h01
`define PIT_OP_I          3'h4
`define PIT_OP_J_NONE     3'h0
`define PIT_OP_K_LOAD     3'h4
`define PIT_OP_K_CLEAR    3'h5
`define PIT_OP_K_ENABLE   3'h6
`define PIT_OP_K_DISABLE  3'h7

// ===========================================================================
// interval register layout and reset values
// ===========================================================================
`define PIT_SCALAR_W      64
`define PIT_IVL_W         32
`define PIT_IVL_FORCE_BIT 3
`define PIT_IVL_RESET     32'h0000_0008
`define PIT_CNT_RESET     32'h0000_0008
`define PIT_CNT_ZERO      32'h0000_0000
`define PIT_CNT_STEP      32'h0000_0001

`endif

/* File: hw/pit_pkg.sv */
// ===========================================================================
// shared types of the interval timer
// ===========================================================================
package pit_pkg;

  // decoded timer instruction, binary codes written out
  typedef enum logic [2:0] {
    PIT_CMD_NONE    = 3'h0,
    PIT_CMD_LOAD    = 3'h1,
    PIT_CMD_CLEAR   = 3'h2,
    PIT_CMD_ENABLE  = 3'h3,
    PIT_CMD_DISABLE = 3'h4
  } pit_cmd_t;

endpackage

/* File: hw/pit_cmd_if.sv */
`timescale 1ns/1ps
`default_nettype none

// ===========================================================================
// decoded command carrier between decoder and timer core
// ===========================================================================
interface pit_cmd_if;
  pit_pkg::pit_cmd_t cmd;       // command for this cycle
  logic              priv_fault; // timer opcode seen outside monitor mode

  modport dec (output cmd, output priv_fault);
  modport core (input cmd, input priv_fault);
endinterface

`default_nettype wire

/* File: hw/pit_decode.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pit_defines.svh"

// ===========================================================================
// timer instruction decoder
// ===========================================================================
module pit_decode (
  input  wire logic                       issue_valid,
  input  wire logic [`PIT_PARCEL_W-1:0]   issue_parcel,
  input  wire logic                       monitor_mode,
  pit_cmd_if.dec                          cmd_bus
);

  // map a parcel to a timer command; the load form takes any j field
  function automatic pit_pkg::pit_cmd_t decode_parcel(
    input logic [`PIT_PARCEL_W-1:0] p
  );
    logic [2:0] k;
    logic       base;
    logic       j_zero;
    k      = p[`PIT_F_K_HI:`PIT_F_K_LO];
    base   = (p[`PIT_F_GH_HI:`PIT_F_GH_LO] == `PIT_OP_GH) &&
             (p[`PIT_F_I_HI:`PIT_F_I_LO] == `PIT_OP_I);
    j_zero = (p[`PIT_F_J_HI:`PIT_F_J_LO] == `PIT_OP_J_NONE);
    decode_parcel = pit_pkg::PIT_CMD_NONE;
    if (base && (k == `PIT_OP_K_LOAD)) begin
      decode_parcel = pit_pkg::PIT_CMD_LOAD;
    end else if (base && j_zero && (k == `PIT_OP_K_CLEAR)) begin
      decode_parcel = pit_pkg::PIT_CMD_CLEAR;
    end else if (base && j_zero && (k == `PIT_OP_K_ENABLE)) begin
      decode_parcel = pit_pkg::PIT_CMD_ENABLE;
    end else if (base && j_zero && (k == `PIT_OP_K_DISABLE)) begin
      decode_parcel = pit_pkg::PIT_CMD_DISABLE;
    end
  endfunction

  pit_pkg::pit_cmd_t raw_cmd;
  wire logic         is_timer_op;

  // raw decode, then privilege gating
  assign raw_cmd     = issue_valid ? decode_parcel(issue_parcel)
                                   : pit_pkg::PIT_CMD_NONE;
  assign is_timer_op = (raw_cmd != pit_pkg::PIT_CMD_NONE);
  assign cmd_bus.cmd        = monitor_mode ? raw_cmd : pit_pkg::PIT_CMD_NONE;
  assign cmd_bus.priv_fault = is_timer_op && !monitor_mode;

endmodule

`default_nettype wire

/* File: hw/pit_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pit_defines.svh"

// ===========================================================================
// periodic interval interrupt timer, one per processor
// ===========================================================================
module pit_timer #(
  parameter int IVL_W = `PIT_IVL_W
) (
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  input  wire logic                       issue_valid,
  input  wire logic [`PIT_PARCEL_W-1:0]   issue_parcel,
  input  wire logic [`PIT_SCALAR_W-1:0]   scalar_source_register,
  input  wire logic                       monitor_mode,
  output logic                            cmd_done,
  output logic                            priv_fault,
  output logic                            tick_request,
  output logic                            tick_enabled,
  output logic                            tick_interrupt,
  output logic [IVL_W-1:0]                interval_reload_value,
  output logic [IVL_W-1:0]                interval_count
);

  // =========================================================================
  // instruction decode
  // =========================================================================
  // the decoder is combinational; every command takes effect at the
  // clock edge of the cycle in which it issues
  pit_cmd_if cmd_bus ();

  pit_decode u_decode (
    .issue_valid  (issue_valid),
    .issue_parcel (issue_parcel),
    .monitor_mode (monitor_mode),
    .cmd_bus      (cmd_bus)
  );

  // =========================================================================
  // command strobes
  // =========================================================================
  wire logic do_load;
  wire logic do_clear;
  wire logic do_enable;
  wire logic do_disable;
  wire logic any_cmd;

  // one-hot strobes out of the decoded command
  assign do_load    = (cmd_bus.cmd == pit_pkg::PIT_CMD_LOAD);
  assign do_clear   = (cmd_bus.cmd == pit_pkg::PIT_CMD_CLEAR);
  assign do_enable  = (cmd_bus.cmd == pit_pkg::PIT_CMD_ENABLE);
  assign do_disable = (cmd_bus.cmd == pit_pkg::PIT_CMD_DISABLE);
  assign any_cmd    = do_load | do_clear | do_enable | do_disable;

  // =========================================================================
  // interval register next value
  // =========================================================================
  wire logic [IVL_W-1:0] load_value;
  wire logic [IVL_W-1:0] force_mask;
  wire logic [IVL_W-1:0] next_interval;

  // the forced bit keeps the smallest period at nine cycles, so a zero
  // operand can never stall the counter on a zero reload
  assign force_mask = IVL_W'(1) << `PIT_IVL_FORCE_BIT;
  assign load_value = scalar_source_register[IVL_W-1:0] | force_mask;
  assign next_interval = do_load ? load_value : interval_reload_value;

  // interval register storage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      interval_reload_value <= IVL_W'(`PIT_IVL_RESET);
    end else begin
      interval_reload_value <= next_interval;
    end
  end

  // =========================================================================
  // down-counter
  // =========================================================================
  wire logic             count_zero;
  wire logic [IVL_W-1:0] count_dec;
  wire logic [IVL_W-1:0] next_count;

  // a count of zero is held for one cycle before the reload, which gives
  // the reload value plus one cycles per period
  assign count_zero = (interval_count == IVL_W'(`PIT_CNT_ZERO));
  assign count_dec  = interval_count - IVL_W'(`PIT_CNT_STEP);
  assign next_count = do_load    ? load_value :
                      count_zero ? interval_reload_value :
                                   count_dec;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      interval_count <= IVL_W'(`PIT_CNT_RESET);
    end else begin
      interval_count <= next_count;
    end
  end

  // =========================================================================
  // request enable
  // =========================================================================
  wire logic next_enabled;

  assign next_enabled = do_enable  ? 1'b1 :
                        do_disable ? 1'b0 :
                                     tick_enabled;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_enabled <= 1'b0;
    end else begin
      tick_enabled <= next_enabled;
    end
  end

  // =========================================================================
  // sticky tick request
  // =========================================================================
  wire logic tick_set;
  wire logic next_request;

  // a load presets the counter, so a zero seen in that same cycle is
  // dropped; the new period starts cleanly from the new value
  // set only when enabled
  assign tick_set = count_zero && !do_load && tick_enabled;
  // sticky until clear
  // a set that meets a clear in the same cycle wins, so no tick is lost
  assign next_request = tick_set | (tick_request & !do_clear);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_request <= 1'b0;
    end else begin
      tick_request <= next_request;
    end
  end

  // =========================================================================
  // interrupt presentation
  // =========================================================================
  wire logic next_interrupt;

  // the request itself is never touched by monitor mode; only its
  // presentation is gated, so it is held across a monitor-mode stretch
  // masked in monitor mode
  assign next_interrupt = tick_request && !monitor_mode;

  // registered so the exchange logic sees a clean level; costs one cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_interrupt <= 1'b0;
    end else begin
      tick_interrupt <= next_interrupt;
    end
  end

  // =========================================================================
  // issue answers
  // =========================================================================
  // one-cycle pulses in the cycle after the instruction issued
  // refuse outside monitor
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_done   <= 1'b0;
      priv_fault <= 1'b0;
    end else begin
      cmd_done   <= any_cmd;
      priv_fault <= cmd_bus.priv_fault;
    end
  end

endmodule

`default_nettype wire

/* File: test/pit_timer_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// timer checker, sees top ports only
// ==================================================
module pit_timer_chk #(
  parameter int IVL_W = 32
) (
  input wire logic             ref_clk,
  input wire logic             rst_n,
  input wire logic             issue_valid,
  input wire logic [15:0]      issue_parcel,
  input wire logic [63:0]      scalar_source_register,
  input wire logic             monitor_mode,
  input wire logic             cmd_done,
  input wire logic             priv_fault,
  input wire logic             tick_request,
  input wire logic             tick_enabled,
  input wire logic             tick_interrupt,
  input wire logic [IVL_W-1:0] interval_reload_value,
  input wire logic [IVL_W-1:0] interval_count
);
  wire logic [2:0]       op_k;
  wire logic             op;
  wire logic             ld;
  wire logic             clr;
  wire logic [IVL_W-1:0] ld_exp;
  logic [IVL_W-1:0]      s_q;
  // decode kept apart from the design so a shared slip is not hidden
  assign op_k = issue_parcel[2:0];
  assign op = issue_valid && issue_parcel[15:6] == 10'h00c &&
    (op_k == 3'h4 || (issue_parcel[5:3] == 3'h0 && op_k > 3'h4));
  assign ld = op && monitor_mode && op_k == 3'h4;
  assign clr = op && monitor_mode && op_k == 3'h5;
  assign ld_exp = {s_q[IVL_W-1:4], 1'b1, s_q[2:0]};
  // operand of the issuing cycle, compared one cycle on
  always_ff @(posedge ref_clk) begin
    s_q <= scalar_source_register[IVL_W-1:0];
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_load_value: assert property (
    ld |=> interval_reload_value == ld_exp) else $error("load value");
  a_load_preset: assert property (
    ld |=> interval_count == interval_reload_value) else $error("preset");
  a_reload_stable: assert property (
    !ld |=> $stable(interval_reload_value)) else $error("reload moved");
  a_count_down: assert property (
    !ld && interval_count != 0 |=> interval_count ==
    $past(interval_count) - 1) else $error("count step");
  a_zero_reload: assert property (
    !ld && interval_count == 0 |=> interval_count ==
    interval_reload_value) else $error("reload");
  a_zero_sets: assert property (
    !ld && interval_count == 0 && tick_enabled |=> tick_request)
    else $error("no set");
  a_set_gated: assert property (
    !tick_enabled && !tick_request |=> !tick_request) else $error("gate");
  a_req_sticky: assert property (
    tick_request && !clr |=> tick_request) else $error("sticky");
  a_intr_masked: assert property (
    monitor_mode |=> !tick_interrupt) else $error("masked");
  a_intr_release: assert property (
    tick_request && !monitor_mode |=> tick_interrupt) else $error("held");
  a_priv_refused: assert property (
    op && !monitor_mode |=> priv_fault && !cmd_done &&
    $stable(tick_enabled)) else $error("refuse");
  a_cmd_answer: assert property (
    op && monitor_mode |=> cmd_done && !priv_fault) else $error("answer");
endmodule
bind pit_timer pit_timer_chk #(.IVL_W(IVL_W)) chk_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .issue_valid(issue_valid),
  .issue_parcel(issue_parcel),
  .scalar_source_register(scalar_source_register),
  .monitor_mode(monitor_mode), .cmd_done(cmd_done),
  .priv_fault(priv_fault), .tick_request(tick_request),
  .tick_enabled(tick_enabled), .tick_interrupt(tick_interrupt),
  .interval_reload_value(interval_reload_value),
  .interval_count(interval_count));
`default_nettype wire

/* File: test/pit_issue_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// instruction issue side of the processor
// ==================================================
module pit_issue_model (
  input  wire logic  ref_clk,
  input  wire logic  cmd_done,
  input  wire logic  priv_fault,
  output logic       issue_valid,
  output logic [15:0] issue_parcel,
  output logic [63:0] scalar_source_register,
  output logic       monitor_mode
);
  initial begin
    issue_valid = 1'b0;
    issue_parcel = 16'hffff;
    scalar_source_register = 64'h0;
    monitor_mode = 1'b1;
  end
  // mode level changes only between instructions
  task automatic set_mon(input logic m);
    @(negedge ref_clk);
    monitor_mode = m;
  endtask
  // caller orders disable then clear, long periods
  task automatic issue(input logic [2:0] k, input logic [63:0] s,
                       output logic d, output logic f);
    @(negedge ref_clk);
    issue_valid = 1'b1;
    issue_parcel = 16'h0300 | {13'h0, k};
    scalar_source_register = s;
    @(negedge ref_clk);
    d = cmd_done;
    f = priv_fault;
    issue_valid = 1'b0;
    // released lines never keep the old value
    issue_parcel = ~issue_parcel;
    scalar_source_register = ~s;
  endtask
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// timer testbench
// ==================================================
module tb_top;
  logic        ref_clk;
  logic        rst_n;
  logic        issue_valid;
  logic [15:0] issue_parcel;
  logic [63:0] scalar_source_register;
  logic        monitor_mode;
  logic        cmd_done;
  logic        priv_fault;
  logic        tick_request;
  logic        tick_enabled;
  logic        tick_interrupt;
  logic [31:0] interval_reload_value;
  logic [31:0] interval_count;
  logic        d;
  logic        f;
  int          n;
  int          err_total;
  int          samples_checked;
  pit_issue_model model_u (.ref_clk(ref_clk), .cmd_done(cmd_done),
    .priv_fault(priv_fault), .issue_valid(issue_valid),
    .issue_parcel(issue_parcel), .monitor_mode(monitor_mode),
    .scalar_source_register(scalar_source_register));
  pit_timer dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .issue_valid(issue_valid), .issue_parcel(issue_parcel),
    .scalar_source_register(scalar_source_register),
    .monitor_mode(monitor_mode), .cmd_done(cmd_done),
    .priv_fault(priv_fault), .tick_request(tick_request),
    .tick_enabled(tick_enabled), .tick_interrupt(tick_interrupt),
    .interval_reload_value(interval_reload_value),
    .interval_count(interval_count));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // cycles until the request shows, bounded
  task automatic wait_req(output int cnt);
    cnt = 0;
    while (tick_request !== 1'b1) begin
      @(negedge ref_clk);
      cnt++;
      if (cnt > 60) begin
        err_total++;
        $display("ERROR %0t no request", $time);
        summarize();
      end
    end
  endtask
  initial begin
    rst_n = 1'b0;
    err_total = 0;
    samples_checked = 0;
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    check(tick_request, 32'h0);
    check(tick_enabled, 32'h0);
    model_u.issue(3'h5, 64'h0, d, f);
    model_u.issue(3'h7, 64'h0, d, f);
    check(d, 32'h1);
    // upper operand half set, lower zero: only bit 3 survives
    model_u.issue(3'h4, 64'hffff_ffff_0000_0000, d, f);
    check(interval_reload_value, 32'h8);
    check(interval_count, 32'h8);
    repeat (12) @(negedge ref_clk);
    check(tick_request, 32'h0);
    $display("test disabled done");
    model_u.issue(3'h4, 64'h10, d, f);
    check(interval_reload_value, 32'h18);
    model_u.issue(3'h6, 64'h0, d, f);
    check(tick_enabled, 32'h1);
    // two issue slots already spent after the preset
    wait_req(n);
    check(n, 32'h17);
    repeat (30) @(negedge ref_clk);
    check(tick_request, 32'h1);
    check(tick_interrupt, 32'h0);
    model_u.set_mon(1'b0);
    @(negedge ref_clk);
    check(tick_interrupt, 32'h1);
    $display("test period done");
    model_u.issue(3'h4, 64'h0, d, f);
    check(f, 32'h1);
    check(interval_reload_value, 32'h18);
    model_u.issue(3'h7, 64'h0, d, f);
    check(tick_enabled, 32'h1);
    model_u.set_mon(1'b1);
    // disable before clear so no zero can set it again
    model_u.issue(3'h7, 64'h0, d, f);
    model_u.issue(3'h5, 64'h0, d, f);
    check(tick_request, 32'h0);
    $display("test refuse done");
    model_u.issue(3'h4, 64'h0, d, f);
    model_u.issue(3'h6, 64'h0, d, f);
    wait_req(n);
    check(n, 32'h7);
    $display("test minimum done");
    summarize();
  end
endmodule
`default_nettype wire
